// ---- logic/nvm_command_issue_regs.sv ----
// Behaviour
// RULE1: a command starts only when the key 0xA5 is written together with the command field.
// RULE2: any other key value blocks the command and sets the programming error flag.
// RULE3: a command issued while another is unfinished sets the programming error flag.
// RULE4: software writes command and key in one single access.
// RULE5: a command write meeting a memory-bus access in the same cycle yields to the memory bus.
// RULE6: a deferred command runs only once both the array and the memory bus are idle.
// RULE7: software issues commands only while the ready flag reads one.
// RULE8: bit 0 of the key field reads one until the command has been issued.
// RULE9: the address field holds a halfword address, one step per 16-bit location.
// RULE10: the registers take 8, 16 and 32-bit accesses.
// RULE11: each byte and halfword of a register can be read and written on its own.
// RULE12: command in bits 6:0, key in bits 15:8, reset value zero.
// RULE13: enable-protected registers ignore writes while the module is enabled.
// RULE14: ready is low and memory-bus accesses stall while an operation runs.
// RULE15: 0x02 erases a row, 0x04 writes a page, 0x40 locks, 0x41 unlocks, 0x44 clears the buffer.
// RULE16: erasing a row in a locked region is refused and sets the lock error flag.
// RULE17: the error interrupt flag sets whenever programming or lock error sets.
module nvm_command_issue_regs #(
    parameter int op_cycles = 16,
    parameter logic [15:0] page_count = 16'h0100,
    parameter logic [2:0] page_size_code = 3'h0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // peripheral register port
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [5:0] reg_addr,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // memory bus
    input wire logic mem_access,
    output logic mem_stall,
    // module enable, for enable-protected registers
    input wire logic module_enable,
    // array sequencer
    output logic op_start,
    output logic [6:0] op_command,
    input wire logic op_done,
    output logic array_busy
);
    logic [31:0] wmask;
    logic wr_cmd;
    logic wr_cfg;
    logic wr_ien_clr;
    logic wr_ien_set;
    logic wr_flag;
    logic wr_stat;
    logic wr_addr;
    logic key_ok;
    logic cmd_pending;
    logic launch;
    logic region_locked;
    logic op_finish;
    logic [31:0] rd_mux;
    logic [31:0] cfg_q;
    logic [21:0] addr_q;
    logic [15:0] lock_q;
    logic [6:0] cmd_q;
    logic [7:0] key_q;
    logic [1:0] ien_q;
    logic [1:0] flag_q;
    logic [4:0] stat_q;
    logic [6:0] pend_cmd_q;
    logic [31:0] cnt_q;
    logic prog_err_set;
    logic lock_err_set;
    logic [3:0] region_idx;
    logic [15:0] region_bit;
    nvm_regs_pkg::seq_state_type state_q;
    nvm_regs_pkg::seq_state_type state_d;

    // byte-lane mask so 8, 16 and 32-bit writes touch only their lanes
    assign wmask = {{8{reg_byte_en[3]}}, {8{reg_byte_en[2]}}, {8{reg_byte_en[1]}}, {8{reg_byte_en[0]}}}; // see RULE11
    assign wr_cmd = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_command_control);
    assign wr_cfg = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_controller_config) && !module_enable; // see RULE13
    assign wr_ien_clr = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_interrupt_enable_clear);
    assign wr_ien_set = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_interrupt_enable_set);
    assign wr_flag = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_interrupt_flags);
    assign wr_stat = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_controller_status);
    assign wr_addr = reg_sel && reg_write && (reg_addr == nvm_regs_pkg::off_target_address);

    // key must arrive in the same access as the command byte
    assign key_ok = wr_cmd && reg_byte_en[1] && (reg_wdata[15:8] == nvm_regs_pkg::exec_key); // see RULE1
    assign prog_err_set = (wr_cmd && reg_byte_en[1] && !key_ok)
        || (key_ok && (state_q != nvm_regs_pkg::st_idle)); // see RULE2 see RULE3
    assign cmd_pending = key_ok && (state_q == nvm_regs_pkg::st_idle);
    // memory bus wins a tie; the command waits for both sides to go quiet
    assign launch = (state_q == nvm_regs_pkg::st_wait) && !mem_access; // see RULE5 see RULE6

    // address counts halfwords: 8 kB regions hold 2^12 halfwords
    assign region_idx = addr_q[nvm_regs_pkg::region_shift +: 4]; // see RULE9
    assign region_bit = 16'h0001 << region_idx;
    assign region_locked = |(lock_q & region_bit);
    assign lock_err_set = launch && (pend_cmd_q == nvm_regs_pkg::cmd_erase_row) && region_locked; // see RULE16
    assign op_finish = (state_q == nvm_regs_pkg::st_busy) && (op_done || (cnt_q == 32'h0000_0000));

    always_comb begin
        state_d = state_q;
        case (state_q)
            nvm_regs_pkg::st_idle: begin
                if (cmd_pending) begin
                    state_d = nvm_regs_pkg::st_wait;
                end
            end
            nvm_regs_pkg::st_wait: begin
                if (launch) begin
                    state_d = lock_err_set ? nvm_regs_pkg::st_idle : nvm_regs_pkg::st_busy;
                end
            end
            nvm_regs_pkg::st_busy: begin
                if (op_finish) begin
                    state_d = nvm_regs_pkg::st_idle;
                end
            end
            default: begin
                state_d = nvm_regs_pkg::st_idle;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= nvm_regs_pkg::st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_cmd_q <= nvm_regs_pkg::command_control_reset[6:0];
            cnt_q <= 32'h0000_0000;
        end else begin
            if (cmd_pending) begin
                pend_cmd_q <= reg_wdata[6:0];
            end
            if (launch) begin
                cnt_q <= 32'(op_cycles);
            end else if (cnt_q != 32'h0000_0000) begin
                cnt_q <= cnt_q - 32'h0000_0001;
            end
        end
    end

    // command register; key bit 0 stays one until issue
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= nvm_regs_pkg::command_control_reset[6:0]; // see RULE12
            key_q <= nvm_regs_pkg::command_control_reset[15:8];
        end else begin
            if (wr_cmd && reg_byte_en[0]) begin
                cmd_q <= reg_wdata[6:0];
            end
            if (launch) begin
                key_q <= 8'h00; // see RULE8
            end else if (wr_cmd && reg_byte_en[1]) begin
                key_q <= {reg_wdata[15:9], 1'b1}; // see RULE8
            end
        end
    end

    // configuration register lanes
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_cfg
            nvm_byte_reg #(
                .width(8),
                .reset_value(nvm_regs_pkg::controller_config_reset[lane*8 +: 8])
            ) u_cfg (
                .clk(clk),
                .sys_rst(sys_rst),
                .wr_en(wr_cfg && reg_byte_en[lane]), // see RULE10
                .wr_data(reg_wdata[lane*8 +: 8] & nvm_regs_pkg::controller_config_mask[lane*8 +: 8]),
                .value_q(cfg_q[lane*8 +: 8])
            );
        end
    endgenerate

    // address register lanes, also loaded per byte
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_q <= 22'h000000;
        end else if (wr_addr) begin
            addr_q <= (addr_q & ~wmask[21:0]) | (reg_wdata[21:0] & wmask[21:0]); // see RULE11
        end
    end

    // region lock bits, changed only by lock and unlock commands
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lock_q <= 16'h0000;
        end else if (launch && (pend_cmd_q == nvm_regs_pkg::cmd_lock_region)) begin
            lock_q <= lock_q | region_bit; // see RULE15
        end else if (launch && (pend_cmd_q == nvm_regs_pkg::cmd_unlock_region)) begin
            lock_q <= lock_q & ~region_bit; // see RULE15
        end
    end

    // interrupt enables: set and clear views of one register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ien_q <= 2'h0;
        end else if (wr_ien_set && reg_byte_en[0]) begin
            ien_q <= ien_q | reg_wdata[1:0];
        end else if (wr_ien_clr && reg_byte_en[0]) begin
            ien_q <= ien_q & ~reg_wdata[1:0];
        end
    end

    // error flags: set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= 5'h00;
            flag_q <= 2'h1;
        end else begin
            stat_q[nvm_regs_pkg::stat_prog_err_bit] <= prog_err_set
                || (stat_q[nvm_regs_pkg::stat_prog_err_bit]
                && !(wr_stat && reg_byte_en[0] && reg_wdata[nvm_regs_pkg::stat_prog_err_bit])); // see RULE2
            stat_q[nvm_regs_pkg::stat_lock_err_bit] <= lock_err_set
                || (stat_q[nvm_regs_pkg::stat_lock_err_bit]
                && !(wr_stat && reg_byte_en[0] && reg_wdata[nvm_regs_pkg::stat_lock_err_bit])); // see RULE16
            stat_q[nvm_regs_pkg::stat_mem_err_bit] <= stat_q[nvm_regs_pkg::stat_mem_err_bit]
                && !(wr_stat && reg_byte_en[0] && reg_wdata[nvm_regs_pkg::stat_mem_err_bit]);
            stat_q[1:0] <= 2'h0;
            flag_q[nvm_regs_pkg::flag_error_bit] <= prog_err_set || lock_err_set
                || (flag_q[nvm_regs_pkg::flag_error_bit]
                && !(wr_flag && reg_byte_en[0] && reg_wdata[nvm_regs_pkg::flag_error_bit])); // see RULE17
            // ready is low from key acceptance until the operation ends
            flag_q[nvm_regs_pkg::flag_ready_bit] <= (state_d == nvm_regs_pkg::st_idle); // see RULE14
        end
    end

    // read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (reg_addr == nvm_regs_pkg::off_command_control) begin
            rd_mux = {16'h0000, key_q, 1'b0, cmd_q};
        end else if (reg_addr == nvm_regs_pkg::off_controller_config) begin
            rd_mux = cfg_q;
        end else if (reg_addr == nvm_regs_pkg::off_memory_parameters) begin
            rd_mux = {13'h0000, page_size_code, page_count};
        end else if (reg_addr == nvm_regs_pkg::off_interrupt_enable_clear) begin
            rd_mux = {30'h0000_0000, ien_q};
        end else if (reg_addr == nvm_regs_pkg::off_interrupt_enable_set) begin
            rd_mux = {30'h0000_0000, ien_q};
        end else if (reg_addr == nvm_regs_pkg::off_interrupt_flags) begin
            rd_mux = {30'h0000_0000, flag_q};
        end else if (reg_addr == nvm_regs_pkg::off_controller_status) begin
            rd_mux = {27'h0000000, stat_q};
        end else if (reg_addr == nvm_regs_pkg::off_target_address) begin
            rd_mux = {10'h000, addr_q};
        end else if (reg_addr == nvm_regs_pkg::off_region_lock_bits) begin
            rd_mux = {16'h0000, lock_q};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
            mem_stall <= 1'b0;
            op_start <= 1'b0;
            op_command <= 7'h00;
            array_busy <= 1'b0;
        end else begin
            reg_rdata <= (reg_sel && !reg_write) ? (rd_mux & wmask) : 32'h0000_0000; // see RULE10
            mem_stall <= (state_d == nvm_regs_pkg::st_busy); // see RULE14
            op_start <= launch && !lock_err_set; // see RULE6
            op_command <= pend_cmd_q;
            array_busy <= (state_d == nvm_regs_pkg::st_busy);
        end
    end

    ready_low_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q != nvm_regs_pkg::st_idle) |-> !flag_q[nvm_regs_pkg::flag_ready_bit])
        else $error("ready high while busy"); // see RULE14
    bad_key_err_a: assert property (@(posedge clk) disable iff (sys_rst)
        (wr_cmd && reg_byte_en[1] && reg_wdata[15:8] != nvm_regs_pkg::exec_key)
        |=> stat_q[nvm_regs_pkg::stat_prog_err_bit] && flag_q[nvm_regs_pkg::flag_error_bit])
        else $error("bad key not flagged"); // see RULE2
    overlap_err_a: assert property (@(posedge clk) disable iff (sys_rst)
        (key_ok && state_q == nvm_regs_pkg::st_busy) |=> stat_q[nvm_regs_pkg::stat_prog_err_bit])
        else $error("overlap not flagged"); // see RULE3
    bus_first_a: assert property (@(posedge clk) disable iff (sys_rst)
        mem_access |=> !op_start)
        else $error("command beat memory bus"); // see RULE5
    start_key_a: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(op_start) |-> $past(state_q) == nvm_regs_pkg::st_wait)
        else $error("start without key"); // see RULE1
    key_bit_a: assert property (@(posedge clk) disable iff (sys_rst)
        key_ok |=> key_q[0])
        else $error("key bit 0 not held"); // see RULE8
    locked_erase_a: assert property (@(posedge clk) disable iff (sys_rst)
        lock_err_set |=> stat_q[nvm_regs_pkg::stat_lock_err_bit] && !op_start)
        else $error("locked erase ran"); // see RULE16
    cfg_protect_a: assert property (@(posedge clk) disable iff (sys_rst)
        module_enable |=> $stable(cfg_q))
        else $error("protected write taken"); // see RULE13
endmodule

// ---- logic/nvm_regs_pkg.sv ----
package nvm_regs_pkg;
    // register byte offsets
    localparam logic [5:0] off_command_control = 6'h00;
    localparam logic [5:0] off_controller_config = 6'h04;
    localparam logic [5:0] off_memory_parameters = 6'h08;
    localparam logic [5:0] off_interrupt_enable_clear = 6'h0C;
    localparam logic [5:0] off_interrupt_enable_set = 6'h10;
    localparam logic [5:0] off_interrupt_flags = 6'h14;
    localparam logic [5:0] off_controller_status = 6'h18;
    localparam logic [5:0] off_target_address = 6'h1C;
    localparam logic [5:0] off_region_lock_bits = 6'h20;
    // key and command codes
    localparam logic [7:0] exec_key = 8'hA5;
    localparam logic [6:0] cmd_erase_row = 7'h02;
    localparam logic [6:0] cmd_write_page = 7'h04;
    localparam logic [6:0] cmd_lock_region = 7'h40;
    localparam logic [6:0] cmd_unlock_region = 7'h41;
    localparam logic [6:0] cmd_clear_buffer = 7'h44;
    // reset values
    localparam logic [15:0] command_control_reset = 16'h0000;
    localparam logic [31:0] controller_config_reset = 32'h0000_0080;
    localparam logic [31:0] controller_config_mask = 32'h000F_039E;
    // field positions
    localparam int flag_ready_bit = 0;
    localparam int flag_error_bit = 1;
    localparam int stat_prog_err_bit = 2;
    localparam int stat_lock_err_bit = 3;
    localparam int stat_mem_err_bit = 4;
    localparam int addr_width = 22;
    localparam int region_shift = 12;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_wait = 2'b01,
        st_busy = 2'b10
    } seq_state_type;
endpackage

// ---- logic/nvm_byte_reg.sv ----
// one byte-lane register: writes are taken per byte enable
module nvm_byte_reg #(
    parameter int width = 8,
    parameter logic [7:0] reset_value = 8'h00
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // write port
    input wire logic wr_en,
    input wire logic [width-1:0] wr_data,
    // stored value
    output logic [width-1:0] value_q
);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            value_q <= reset_value[width-1:0];
        end else if (wr_en) begin
            value_q <= wr_data;
        end
    end
endmodule

// ---- bench/nvm_array_model.sv ----
// stands in for the array sequencer behind the controller
module nvm_array_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // launch from the controller; a delay of zero never answers
    input wire logic op_start,
    input wire logic [7:0] done_delay,
    // completion pulse back
    output logic op_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] count_q;
    logic running_q;
    // a silent array forces the controller to end the operation by its own timeout
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            running_q <= 1'b0;
            count_q <= 8'h00;
            op_done <= 1'b0;
        end else begin
            op_done <= running_q && count_q == 8'h01;
            if (op_start) begin
                running_q <= done_delay != 8'h00;
                count_q <= done_delay;
            end else if (running_q) begin
                count_q <= count_q - 8'h01;
                running_q <= count_q != 8'h01;
            end
        end
    end
endmodule

// ---- bench/nvm_command_issue_regs_tb.sv ----
module nvm_command_issue_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} note_type;
    logic clk, sys_rst, reg_sel, reg_write, mem_access, mem_stall, module_enable;
    logic op_start, op_done, array_busy, rd_pend;
    logic [5:0] reg_addr;
    logic [3:0] reg_byte_en;
    logic [31:0] reg_wdata, reg_rdata, lfsr_q;
    logic [6:0] op_command;
    logic [7:0] done_delay, key;
    note_type rd_q[$];
    note_type note;
    logic [6:0] cmd_q[$];
    int bad_count, num_checks;

    nvm_command_issue_regs i_dut (.clk(clk), .sys_rst(sys_rst), .reg_sel(reg_sel), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mem_access(mem_access), .mem_stall(mem_stall), .module_enable(module_enable), .op_start(op_start),
        .op_command(op_command), .op_done(op_done), .array_busy(array_busy));
    nvm_array_model i_array (.clk(clk), .sys_rst(sys_rst), .op_start(op_start), .done_delay(done_delay),
        .op_done(op_done));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (cmd_q.size() != 0) bad_count++;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one access per call; the request stands through exactly one rising edge
    task automatic access(input logic wr, input logic [5:0] addr, input logic [3:0] be, input logic [31:0] data);
        @(negedge clk);
        reg_sel = 1'b1;
        reg_write = wr;
        reg_addr = addr;
        reg_byte_en = be;
        reg_wdata = data;
        @(negedge clk);
        reg_sel = 1'b0;
    endtask

    task automatic rd(input logic [5:0] addr, input logic [3:0] be, input logic [31:0] exp, input logic [31:0] mask);
        rd_q.push_back('{exp, mask});
        access(1'b0, addr, be, 32'h0000_0000);
    endtask

    task automatic issue(input logic [6:0] cmd, input logic [7:0] k, input bit launches);
        if (launches) cmd_q.push_back(cmd);
        access(1'b1, nvm_regs_pkg::off_command_control, 4'h3, {16'h0000, k, 1'b0, cmd});
    endtask

    task automatic wait_idle();
        repeat (3) @(negedge clk);
        // next command only once the array is quiet again, so ready reads one
        for (int i = 0; i < 200 && array_busy !== 1'b0; i++) @(negedge clk);
        check("array idle", 32'h0, {31'h0, array_busy});
        @(negedge clk);
    endtask

    task automatic clear_errors();
        access(1'b1, nvm_regs_pkg::off_controller_status, 4'h1, 32'h0000_001C);
        access(1'b1, nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h0000_0002);
    endtask

    // results are judged here, against the oldest note left by the driver
    always @(posedge clk) rd_pend <= reg_sel && !reg_write;
    always @(negedge clk) begin
        if (rd_pend === 1'b1) begin
            note = rd_q.pop_front();
            check("read data", note.exp, reg_rdata & note.mask);
        end
        if (op_start === 1'b1) begin
            if (cmd_q.size() == 0) check("unexpected launch", 32'h0, 32'h1);
            else check("launched command", {25'h0, cmd_q.pop_front()}, {25'h0, op_command});
        end
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        complete_run();
    end

    initial begin
        {reg_sel, reg_write, mem_access, module_enable} = '0;
        reg_addr = 6'h00;
        reg_byte_en = 4'h0;
        reg_wdata = 32'h0000_0000;
        done_delay = 8'h03;
        lfsr_q = 32'h0000_D1A6;
        sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        rd(nvm_regs_pkg::off_command_control, 4'hF, 32'h0, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_controller_config, 4'hF, 32'h80, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_interrupt_flags, 4'hF, 32'h1, 32'h3);
        rd(6'h24, 4'hF, 32'h0, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_memory_parameters, 4'hF, 32'h0000_0100, 32'hFFFF_FFFF);
        // set and clear views share one enable register
        access(1'b1, nvm_regs_pkg::off_interrupt_enable_set, 4'h1, 32'h0000_0003);
        rd(nvm_regs_pkg::off_interrupt_enable_clear, 4'hF, 32'h3, 32'hFFFF_FFFF);
        access(1'b1, nvm_regs_pkg::off_interrupt_enable_clear, 4'h1, 32'h0000_0001);
        rd(nvm_regs_pkg::off_interrupt_enable_set, 4'h1, 32'h2, 32'hFFFF_FFFF);
        // protected configuration only moves while the module is off
        module_enable = 1'b1;
        access(1'b1, nvm_regs_pkg::off_controller_config, 4'hF, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_controller_config, 4'hF, 32'h80, 32'hFFFF_FFFF);
        module_enable = 1'b0;
        access(1'b1, nvm_regs_pkg::off_controller_config, 4'hF, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_controller_config, 4'hF, 32'h000F_039E, 32'hFFFF_FFFF);
        // lane accesses on the address register
        access(1'b1, nvm_regs_pkg::off_target_address, 4'hF, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_target_address, 4'hF, 32'h003F_FFFF, 32'hFFFF_FFFF);
        access(1'b1, nvm_regs_pkg::off_target_address, 4'h2, 32'h0000_1200);
        rd(nvm_regs_pkg::off_target_address, 4'hF, 32'h003F_12FF, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_target_address, 4'h4, 32'h003F_0000, 32'hFFFF_FFFF);
        rd(nvm_regs_pkg::off_target_address, 4'h3, 32'h0000_12FF, 32'hFFFF_FFFF);
        // halfword address 0x3000 lies in region 3
        access(1'b1, nvm_regs_pkg::off_target_address, 4'hF, 32'h0000_3000);
        mem_access = 1'b1;
        issue(nvm_regs_pkg::cmd_erase_row, nvm_regs_pkg::exec_key, 1'b1);
        rd(nvm_regs_pkg::off_command_control, 4'h3, 32'h0100, 32'h0100);
        rd(nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h0, 32'h1);
        repeat (5) @(negedge clk);
        check("deferred launch", 32'h1, cmd_q.size());
        mem_access = 1'b0;
        wait_idle();
        rd(nvm_regs_pkg::off_command_control, 4'h3, 32'h0, 32'hFF00);
        // a silent array: the controller times out, a second command meanwhile is refused
        done_delay = 8'h00;
        issue(nvm_regs_pkg::cmd_write_page, nvm_regs_pkg::exec_key, 1'b1);
        repeat (3) @(negedge clk);
        check("stall while busy", 32'h1, {31'h0, mem_stall});
        rd(nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h0, 32'h1);
        issue(nvm_regs_pkg::cmd_clear_buffer, nvm_regs_pkg::exec_key, 1'b0);
        wait_idle();
        rd(nvm_regs_pkg::off_controller_status, 4'h3, 32'h04, 32'h1C);
        rd(nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h3, 32'h3);
        clear_errors();
        rd(nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h1, 32'h3);
        done_delay = 8'h03;
        for (int i = 0; i < 4; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            key = (lfsr_q[7:0] == nvm_regs_pkg::exec_key) ? 8'h5A : lfsr_q[7:0];
            issue(nvm_regs_pkg::cmd_write_page, key, 1'b0);
            rd(nvm_regs_pkg::off_controller_status, 4'h1, 32'h04, 32'h1C);
            clear_errors();
        end
        issue(nvm_regs_pkg::cmd_lock_region, nvm_regs_pkg::exec_key, 1'b1);
        wait_idle();
        rd(nvm_regs_pkg::off_region_lock_bits, 4'h3, 32'h0008, 32'hFFFF);
        issue(nvm_regs_pkg::cmd_erase_row, nvm_regs_pkg::exec_key, 1'b0);
        wait_idle();
        rd(nvm_regs_pkg::off_controller_status, 4'h1, 32'h08, 32'h1C);
        rd(nvm_regs_pkg::off_interrupt_flags, 4'h1, 32'h3, 32'h3);
        clear_errors();
        issue(nvm_regs_pkg::cmd_unlock_region, nvm_regs_pkg::exec_key, 1'b1);
        wait_idle();
        rd(nvm_regs_pkg::off_region_lock_bits, 4'h3, 32'h0000, 32'hFFFF);
        issue(nvm_regs_pkg::cmd_erase_row, nvm_regs_pkg::exec_key, 1'b1);
        wait_idle();
        issue(nvm_regs_pkg::cmd_clear_buffer, nvm_regs_pkg::exec_key, 1'b1);
        wait_idle();
        rd(nvm_regs_pkg::off_controller_status, 4'h1, 32'h00, 32'h1C);
        repeat (4) @(negedge clk);
        complete_run();
    end
endmodule
